//--- mii_fbi_port_config.sv
// Port configuration and controller-side pin logic of a 100/10 twisted pair transceiver.
// Assumes an APB master on pclk, a media core clocked by the oscillator input, and
// straps that are stable around reset.
`timescale 1ns/1ns
module mii_fbi_port_config #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic [ADDR_W-1:0] paddr, // APB byte address
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error for unmapped or read-only write
	input wire logic [4:0] strapped_station_address, // Address strap pins
	input wire logic repeater_strap_pin, // Repeater mode strap
	input wire logic oscillator_input, // 25 MHz link clock
	output logic tx_clk_o, // Transmit clock out
	output logic tx_clk_oe, // Transmit clock drive enable
	input wire logic [4:0] txd, // Transmit data, bit 4 used in five bit mode
	input wire logic tx_en, // Transmit enable
	input wire logic shared_rxen_jam_pin, // Receive enable or jam pin
	output logic rx_clk_o, // Receive clock out
	output logic [4:0] rxd_o, // Receive data
	output logic rx_dv_o, // Receive data valid
	output logic rx_er_o, // Receive error
	output logic col_o, // Collision
	output logic rx_oe, // Drive enable of the receive group
	output logic crs_o, // Carrier sense
	output logic crs_oe, // Carrier sense drive enable
	input mii_fbi_pkg::rx_group_t core_rx, // Receive group from the media core
	input wire logic core_crs, // Line carrier from the media core
	output logic [4:0] core_tx_data, // Transmit symbols to the media core
	output logic core_tx_en, // Transmit enable to the media core
	output logic twisted_pair_output_en, // Twisted pair driver enable
	output mii_fbi_pkg::link_cfg_t core_cfg, // Mode settings for the media core
	output mii_fbi_pkg::tx_current_t tx_current_sel // Transmit current level select
);

	// ********************************************************************
	// Strap synchronisers and capture
	// ********************************************************************
	logic [4:0] addr_s1_q;
	logic [4:0] addr_s2_q;
	logic strap_rep_s1_q;
	logic strap_rep_s2_q;
	logic [1:0] settle_q;
	logic captured_q;
	logic [4:0] strap_addr_q;
	logic cap_pulse;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_s1_q <= 5'h00;
			addr_s2_q <= 5'h00;
			strap_rep_s1_q <= 1'b0;
			strap_rep_s2_q <= 1'b0;
		end
		else
		begin
			addr_s1_q <= strapped_station_address;
			addr_s2_q <= addr_s1_q;
			strap_rep_s1_q <= repeater_strap_pin;
			strap_rep_s2_q <= strap_rep_s1_q;
		end
	end

	// The address is taken once, after the synchroniser has filled.
	assign cap_pulse = !captured_q && (settle_q == mii_fbi_pkg::STRAP_SETTLE);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			settle_q <= 2'h0;
			captured_q <= 1'b0;
			strap_addr_q <= 5'h00;
		end
		else
		begin
			if (settle_q != mii_fbi_pkg::STRAP_SETTLE)
				settle_q <= settle_q + 2'h1;
			if (cap_pulse)
			begin
				captured_q <= 1'b1;
				strap_addr_q <= addr_s2_q;
			end
		end
	end

	// ********************************************************************
	// APB slave and registers
	// ********************************************************************
	logic [3:0] control_q;
	logic [3:0] config1_q;
	logic config2_q;
	logic wr_acc;
	logic rd_acc;
	logic [7:0] ofs;
	logic mapped;
	logic rx_oe_p1_q;
	logic rx_oe_p2_q;

	assign ofs = 8'(paddr);
	assign mapped = (ofs == mii_fbi_pkg::CONTROL_OFS) || (ofs == mii_fbi_pkg::CONFIG1_OFS)
		|| (ofs == mii_fbi_pkg::CONFIG2_OFS) || (ofs == mii_fbi_pkg::STATUS_OFS);
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable
		&& (!mapped || (pwrite && ofs == mii_fbi_pkg::STATUS_OFS));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			control_q <= mii_fbi_pkg::CONTROL_RST;
		else if (cap_pulse)
		begin
			// Shared-bus strap keeps the port off; any other address turns it on.
			control_q[mii_fbi_pkg::CTL_PORT_DIS_BIT] <=
				(addr_s2_q == mii_fbi_pkg::SHARED_BUS_ADDR); // RQ3 RQ4
		end
		else if (wr_acc && ofs == mii_fbi_pkg::CONTROL_OFS)
			control_q <= pwdata[3:0]; // RQ2 RQ11
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			config1_q <= mii_fbi_pkg::CONFIG1_RST;
			config2_q <= mii_fbi_pkg::CONFIG2_RST;
		end
		else
		begin
			if (wr_acc && ofs == mii_fbi_pkg::CONFIG1_OFS)
				config1_q <= pwdata[3:0]; // RQ1 RQ8 RQ9 RQ10
			if (wr_acc && ofs == mii_fbi_pkg::CONFIG2_OFS)
				config2_q <= pwdata[0]; // RQ6
		end
	end

	// ********************************************************************
	// Effective settings
	// ********************************************************************
	mii_fbi_pkg::link_cfg_t cfg;

	always_comb
	begin
		cfg.port_dis = control_q[mii_fbi_pkg::CTL_PORT_DIS_BIT];
		cfg.rxen_sel = config2_q;
		cfg.five_bit = config1_q[mii_fbi_pkg::CF1_ENC_BYP_BIT]; // RQ7 RQ8
		cfg.scr_byp = config1_q[mii_fbi_pkg::CF1_SCR_BYP_BIT]; // RQ9
		cfg.cable_stp = config1_q[mii_fbi_pkg::CF1_STP_BIT];
		// The repeater strap overrides software, since it reflects the board wiring.
		cfg.loop_dis = config1_q[mii_fbi_pkg::CF1_LOOP_DIS_BIT] || strap_rep_s2_q; // RQ10 RQ12
		cfg.autoneg = control_q[mii_fbi_pkg::CTL_AUTONEG_BIT] && !strap_rep_s2_q; // RQ11 RQ12
		cfg.full_duplex = !control_q[mii_fbi_pkg::CTL_HALF_BIT] && !strap_rep_s2_q; // RQ11 RQ12
		cfg.speed_100 = control_q[mii_fbi_pkg::CTL_SPEED100_BIT] || strap_rep_s2_q; // RQ11 RQ12
	end

	// The settings are registered before they cross, so that decode glitches in the
	// combinational merge can never be caught by the link-side flops.
	mii_fbi_pkg::link_cfg_t cfg_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_q <= mii_fbi_pkg::link_cfg_t'({1'b1, 8'h00});
		else
			cfg_q <= cfg;
	end

	// Current level depends on speed and cable only; it is a static analog setting.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_current_sel <= mii_fbi_pkg::CUR_100_UTP;
		else
			tx_current_sel <= mii_fbi_pkg::tx_current_t'({!cfg.speed_100, cfg.cable_stp}); // RQ1
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			unique case (ofs)
				mii_fbi_pkg::CONTROL_OFS: prdata <= {28'h0000000, control_q};
				mii_fbi_pkg::CONFIG1_OFS: prdata <= {28'h0000000, config1_q};
				mii_fbi_pkg::CONFIG2_OFS: prdata <= {31'h00000000, config2_q};
				mii_fbi_pkg::STATUS_OFS: prdata <= {14'h0000, rx_oe_p2_q, strap_rep_s2_q,
					strap_addr_q, cfg.five_bit, 1'b0, cfg.loop_dis, cfg.autoneg,
					cfg.full_duplex, cfg.speed_100, cfg.cable_stp, 4'h0};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ********************************************************************
	// Link domain: reset and settings crossing
	// ********************************************************************
	logic lrst_a_q;
	logic lrst_n_q;
	logic [mii_fbi_pkg::LINK_CFG_W-1:0] cfg_s1_q;
	logic [mii_fbi_pkg::LINK_CFG_W-1:0] cfg_s2_q;
	mii_fbi_pkg::link_cfg_t lcfg;

	always_ff @(posedge oscillator_input or negedge presetn)
	begin
		if (!presetn)
		begin
			lrst_a_q <= 1'b0;
			lrst_n_q <= 1'b0;
		end
		else
		begin
			lrst_a_q <= 1'b1;
			lrst_n_q <= lrst_a_q;
		end
	end

	// Settings are quasi-static levels, so each bit crosses on its own pair of flops.
	generate
		for (genvar i = 0; i < mii_fbi_pkg::LINK_CFG_W; i++)
		begin : g_cfg_sync
			always_ff @(posedge oscillator_input or negedge presetn)
			begin
				if (!presetn)
				begin
					cfg_s1_q[i] <= (i == mii_fbi_pkg::LINK_CFG_W - 1);
					cfg_s2_q[i] <= (i == mii_fbi_pkg::LINK_CFG_W - 1);
				end
				else
				begin
					cfg_s1_q[i] <= cfg_q[i];
					cfg_s2_q[i] <= cfg_s1_q[i];
				end
			end
		end
	endgenerate

	assign lcfg = mii_fbi_pkg::link_cfg_t'(cfg_s2_q);
	assign core_cfg = lcfg;
	assign twisted_pair_output_en = !lcfg.port_dis; // RQ2

	// ********************************************************************
	// Link domain: transmit side
	// ********************************************************************
	// The transmit clock is the oscillator itself, so a master clock driving the
	// oscillator input also times the transmit data.
	assign tx_clk_o = oscillator_input; // RQ13 RQ14
	assign tx_clk_oe = !lcfg.port_dis; // RQ2 RQ13

	always_ff @(posedge oscillator_input or negedge presetn)
	begin
		if (!presetn)
		begin
			core_tx_data <= 5'h00;
			core_tx_en <= 1'b0;
		end
		else if (!lrst_n_q || lcfg.port_dis)
		begin
			core_tx_data <= 5'h00; // RQ2
			core_tx_en <= 1'b0; // RQ2
		end
		else
		begin
			core_tx_data <= lcfg.five_bit ? txd : {1'b0, txd[3:0]}; // RQ7 RQ14
			core_tx_en <= tx_en;
		end
	end

	// ********************************************************************
	// Link domain: receive side
	// ********************************************************************
	logic rx_allow;

	// Enable sampled on the link clock: the repeater core runs from the same master clock.
	assign rx_allow = !lcfg.port_dis && (!lcfg.rxen_sel || shared_rxen_jam_pin); // RQ2 RQ5 RQ6

	always_ff @(posedge oscillator_input or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_oe <= 1'b0;
			crs_oe <= 1'b0;
			rxd_o <= 5'h00;
			rx_dv_o <= 1'b0;
			rx_er_o <= 1'b0;
			col_o <= 1'b0;
			crs_o <= 1'b0;
		end
		else
		begin
			rx_oe <= lrst_n_q && rx_allow; // RQ5 RQ16
			crs_oe <= lrst_n_q && !lcfg.port_dis; // RQ2
			rxd_o <= lcfg.five_bit ? core_rx.data : {1'b0, core_rx.data[3:0]}; // RQ7
			rx_dv_o <= core_rx.dv;
			rx_er_o <= core_rx.er;
			col_o <= core_rx.col;
			crs_o <= core_crs || (tx_en && !lcfg.loop_dis && !lcfg.port_dis); // RQ10
		end
	end

	assign rx_clk_o = oscillator_input;

	// Receive enable state reported back to software.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_oe_p1_q <= 1'b0;
			rx_oe_p2_q <= 1'b0;
		end
		else
		begin
			rx_oe_p1_q <= rx_oe;
			rx_oe_p2_q <= rx_oe_p1_q;
		end
	end

	// ********************************************************************
	// Checks
	// ********************************************************************
	chk_strap_disable: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		cap_pulse && addr_s2_q == 5'h1f |=> control_q[0])
		else $error("shared bus strap did not leave the port disabled");

	chk_strap_enable: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		cap_pulse && addr_s2_q != 5'h1f |=> !control_q[0])
		else $error("single device strap did not enable the port");

	chk_repeater_override: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
		strap_rep_s2_q |-> cfg.loop_dis && !cfg.autoneg && !cfg.full_duplex && cfg.speed_100)
		else $error("repeater strap did not force its settings");

	chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
		wr_acc && ofs == 8'h00 && !cap_pulse && !strap_rep_s2_q
		|=> cfg.speed_100 == $past(pwdata[3]) && cfg.autoneg == $past(pwdata[1]))
		else $error("control write did not steer speed or negotiation");

	chk_five_bit: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		cfg.five_bit == config1_q[1] && cfg.scr_byp == config1_q[2])
		else $error("five bit mode does not follow coder bypass");

	chk_cable_cur: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		##1 tx_current_sel[0] == $past(config1_q[0]))
		else $error("transmit current does not follow cable type");

	chk_tx_inhibit: assert property (@(posedge oscillator_input) disable iff (!presetn) // RQ2
		lcfg.port_dis |-> (!twisted_pair_output_en && !tx_clk_oe) ##1 (!core_tx_en && !crs_oe))
		else $error("transmit not inhibited while port disabled");

	chk_rx_float: assert property (@(posedge oscillator_input) disable iff (!presetn) // RQ5
		lcfg.rxen_sel && !shared_rxen_jam_pin |=> !rx_oe)
		else $error("receive group driven while receive enable is low");

	chk_rx_release: assert property (@(posedge oscillator_input) disable iff (!presetn) // RQ16
		lrst_n_q && !lcfg.port_dis && lcfg.rxen_sel && $rose(shared_rxen_jam_pin) |=> rx_oe)
		else $error("receive group not released within one clock");

	chk_crs_loop: assert property (@(posedge oscillator_input) disable iff (!presetn) // RQ10
		lcfg.loop_dis && !core_crs |=> !crs_o)
		else $error("transmit enable looped onto carrier sense");

	chk_five_bit_data: assert property (@(posedge oscillator_input) disable iff (!presetn) // RQ7
		!lcfg.five_bit |=> !core_tx_data[4] && !rxd_o[4])
		else $error("fifth data bit passed while in four bit mode");

endmodule : mii_fbi_port_config

//--- mii_fbi_pkg.sv
// Constants, register map and carrier types for the controller-side port configuration block.
// Assumes one APB register bus on pclk and one link clock taken from the oscillator input.
//
// What this block does
// RQ1 - A cable type bit picks UTP or STP and sets the transmit current level.
// RQ2 - Port disable floats controller outputs, ignores inputs, stops twisted pair transmit.
// RQ3 - Strapped address 11111 at reset leaves the port disabled for shared buses.
// RQ4 - Any other strapped address leaves the port enabled after reset.
// RQ5 - Receive enable low floats receive clock, data, valid, error and collision outputs.
// RQ6 - The shared pin acts as receive enable only when its select bit is set.
// RQ7 - Bypassing the block coder switches the data path to five bits automatically.
// RQ8 - The encoder bypass bit bypasses the block encoder and decoder.
// RQ9 - The scrambler bypass bit bypasses scrambler and descrambler.
// RQ10 - The loopback disable bit stops transmit enable echoing onto carrier sense.
// RQ11 - Control bits set autonegotiation, forced half duplex and 100 or 10 Mbps.
// RQ12 - Repeater strap forces no loopback, no autonegotiation, half duplex, 100 Mbps.
// RQ13 - The transmit clock is an output; controller data follows it.
// RQ14 - The transmit clock derives from the oscillator input, usable as master clock.
// RQ15 - A repeater core enables receive output on only the one receiving port.
// RQ16 - Receive outputs leave high impedance within one receive clock of enable.
package mii_fbi_pkg;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam logic [7:0] CONTROL_OFS = 8'h00;
	localparam logic [7:0] CONFIG1_OFS = 8'h04;
	localparam logic [7:0] CONFIG2_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;

	// Control register fields.
	localparam int CTL_PORT_DIS_BIT = 0;
	localparam int CTL_AUTONEG_BIT = 1;
	localparam int CTL_HALF_BIT = 2;
	localparam int CTL_SPEED100_BIT = 3;
	// Configuration 1 fields.
	localparam int CF1_STP_BIT = 0;
	localparam int CF1_ENC_BYP_BIT = 1;
	localparam int CF1_SCR_BYP_BIT = 2;
	localparam int CF1_LOOP_DIS_BIT = 3;
	// Configuration 2 fields.
	localparam int CF2_RXEN_SEL_BIT = 0;

	// Reset values; port disable is overwritten by the strap capture.
	localparam logic [3:0] CONTROL_RST = 4'h3;
	localparam logic [3:0] CONFIG1_RST = 4'h0;
	localparam logic CONFIG2_RST = 1'b0;

	// Strap handling.
	localparam logic [4:0] SHARED_BUS_ADDR = 5'h1f;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// Transmit current selection: {ten_mbps, shielded}.
	typedef enum logic [1:0] {
		CUR_100_UTP = 2'h0,
		CUR_100_STP = 2'h1,
		CUR_10_UTP = 2'h2,
		CUR_10_STP = 2'h3
	} tx_current_t;

	// Settings that cross into the link domain and drive the media core.
	typedef struct packed {
		logic port_dis;
		logic rxen_sel;
		logic five_bit;
		logic scr_byp;
		logic loop_dis;
		logic autoneg;
		logic full_duplex;
		logic speed_100;
		logic cable_stp;
	} link_cfg_t;
	localparam int LINK_CFG_W = 9;

	// Receive group handed from the media core to the controller port.
	typedef struct packed {
		logic [4:0] data;
		logic dv;
		logic er;
		logic col;
	} rx_group_t;

endpackage : mii_fbi_pkg

//--- repeater_strap_pin_core_model.sv
// Behavioural repeater core facing the controller port of the transceiver.
// Assumes the link clock is the oscillator input and the bench sets the request flags.
`timescale 1ns/1ns
module repeater_core_model (
	input wire logic osc, // Link clock used as master clock
	input wire logic crs, // Carrier sense from the port
	input wire logic crs_oe, // Carrier sense drive enable
	output logic [4:0] txd, // Transmit data
	output logic tx_en, // Transmit enable
	output logic rxen // Receive enable for the shared pin
);
	logic en_q = 1'b0;
	logic share_q = 1'b0;
	logic [4:0] txd_q = 5'h00;
	initial
	begin
		txd = 5'h00;
		tx_en = 1'b0;
		rxen = 1'b0;
	end
	// Idle data toggles so that a stale value can never pass for a real one.
	always @(posedge osc)
	begin
		txd <= en_q ? txd_q : ~txd;
		tx_en <= en_q;
		rxen <= share_q & crs & crs_oe;
	end
endmodule : repeater_core_model

//--- mii_fbi_port_config_tb.sv
// Self-checking bench for the controller-side port configuration block.
// Assumes the design package is compiled first and the repeater core model beside it.
`timescale 1ns/1ns
module mii_fbi_port_config_tb;
	logic pclk = 1'b0;
	logic oscillator_input = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, e;
	logic [4:0] strapped_station_address = 5'h1f;
	logic repeater_strap_pin = 1'b0;
	logic tx_clk_o, tx_clk_oe, rx_clk_o, rx_dv_o, rx_er_o, col_o, rx_oe, crs_o, crs_oe;
	logic [4:0] txd, rxd_o, core_tx_data;
	logic tx_en, shared_rxen_jam_pin, core_tx_en, twisted_pair_output_en;
	logic core_crs = 1'b0;
	mii_fbi_pkg::rx_group_t core_rx = '{data: 5'h1b, dv: 1'b1, er: 1'b0, col: 1'b1};
	mii_fbi_pkg::link_cfg_t core_cfg;
	mii_fbi_pkg::tx_current_t tx_current_sel;
	int err_count = 0;
	int checked = 0;

	always #5 pclk = ~pclk;
	// Offset keeps link edges away from APB edges.
	initial
	begin
		#2;
		forever #15 oscillator_input = ~oscillator_input;
	end

	mii_fbi_port_config dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .strapped_station_address, .repeater_strap_pin,
		.oscillator_input, .tx_clk_o, .tx_clk_oe, .txd, .tx_en, .shared_rxen_jam_pin,
		.rx_clk_o, .rxd_o, .rx_dv_o, .rx_er_o, .col_o, .rx_oe, .crs_o, .crs_oe, .core_rx,
		.core_crs, .core_tx_data, .core_tx_en, .twisted_pair_output_en, .core_cfg,
		.tx_current_sel);
	repeater_core_model p_u (.osc(oscillator_input), .crs(crs_o), .crs_oe, .txd, .tx_en,
		.rxen(shared_rxen_jam_pin));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask : apb

	// Sampling one step after the link edge lets its updates land first.
	task automatic lw(input int n);
		repeat (n) @(posedge oscillator_input);
		#1;
	endtask : lw

	task automatic do_reset(input logic [4:0] s);
		@(posedge pclk);
		presetn <= 1'b0;
		strapped_station_address <= s;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		lw(6);
	endtask : do_reset

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_shared_bus;
		do_reset(5'h1f);
		apb(1'b0, mii_fbi_pkg::CONTROL_OFS, 32'h0);
		chk("control", 32'h3, rd);
		p_u.txd_q <= 5'h0a;
		p_u.en_q <= 1'b1;
		lw(3);
		chk("tx_en core", 32'h0, 32'(core_tx_en));
		chk("oe", 32'h0, {twisted_pair_output_en, tx_clk_oe, rx_oe});
	endtask : t_shared_bus

	task automatic t_single_bus;
		do_reset(5'h05);
		apb(1'b0, mii_fbi_pkg::CONTROL_OFS, 32'h0);
		chk("control", 32'h2, rd);
		chk("tp oe", 32'h3, {twisted_pair_output_en, tx_clk_oe});
		chk("tx path", 32'h2a, {core_tx_en, core_tx_data});
		chk("rx group", 32'h5, {rx_dv_o, rx_er_o, col_o});
		chk("clocks", {30'h0, oscillator_input, oscillator_input}, {tx_clk_o, rx_clk_o});
	endtask : t_single_bus

	task automatic t_loopback;
		chk("crs echo", 32'h1, 32'(crs_o));
		apb(1'b1, mii_fbi_pkg::CONFIG1_OFS, 32'h8);
		lw(6);
		chk("crs no echo", 32'h0, 32'(crs_o));
		apb(1'b1, mii_fbi_pkg::CONFIG1_OFS, 32'h0);
	endtask : t_loopback

	task automatic t_rx_enable;
		int n;
		chk("rx always", 32'h10b, {rx_oe, 3'h0, rxd_o});
		apb(1'b1, mii_fbi_pkg::CONFIG2_OFS, 32'h1);
		lw(6);
		chk("rx float", 32'h0, 32'(rx_oe));
		core_crs <= 1'b1;
		p_u.share_q <= 1'b1;
		n = 0;
		do
		begin
			lw(1);
			n++;
		end
		while (shared_rxen_jam_pin !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			err_count++;
			tally_and_finish();
		end
		lw(1);
		chk("rx drive", 32'h1, 32'(rx_oe));
		core_crs <= 1'b0;
		p_u.share_q <= 1'b0;
	endtask : t_rx_enable

	task automatic t_modes;
		apb(1'b1, mii_fbi_pkg::CONTROL_OFS, 32'h6);
		apb(1'b1, mii_fbi_pkg::CONFIG1_OFS, 32'h1);
		lw(6);
		chk("modes", 32'h4, {core_cfg.autoneg, core_cfg.full_duplex, core_cfg.speed_100});
		chk("current", 32'(mii_fbi_pkg::CUR_10_STP), 32'(tx_current_sel));
		apb(1'b1, mii_fbi_pkg::CONTROL_OFS, 32'h8);
		lw(6);
		chk("modes", 32'h3, {core_cfg.autoneg, core_cfg.full_duplex, core_cfg.speed_100});
		chk("current", 32'(mii_fbi_pkg::CUR_100_STP), 32'(tx_current_sel));
	endtask : t_modes

	task automatic t_five_bit;
		apb(1'b1, mii_fbi_pkg::CONFIG1_OFS, 32'h6);
		p_u.txd_q <= 5'h15;
		lw(6);
		chk("bypass", 32'h3, {core_cfg.five_bit, core_cfg.scr_byp});
		chk("five bit tx", 32'h35, {core_tx_en, core_tx_data});
		chk("five bit rx", 32'h1b, 32'(rxd_o));
	endtask : t_five_bit

	task automatic t_repeater;
		apb(1'b1, mii_fbi_pkg::CONTROL_OFS, 32'h2);
		repeater_strap_pin <= 1'b1;
		lw(8);
		chk("strap", 32'h9, {core_cfg.loop_dis, core_cfg.autoneg, core_cfg.full_duplex,
			core_cfg.speed_100});
		chk("crs strap", 32'h0, 32'(crs_o));
		apb(1'b0, mii_fbi_pkg::STATUS_OFS, 32'h0);
		chk("status", 32'h12d20, rd);
		repeater_strap_pin <= 1'b0;
	endtask : t_repeater

	task automatic t_refused;
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], e});
		apb(1'b1, mii_fbi_pkg::STATUS_OFS, 32'hffff);
		chk("status write", 32'h1, 32'(e));
	endtask : t_refused

	task automatic t_disable;
		apb(1'b1, mii_fbi_pkg::CONTROL_OFS, 32'h9);
		lw(6);
		chk("disabled", 32'h0, {core_tx_en, twisted_pair_output_en, tx_clk_oe, rx_oe, crs_oe});
	endtask : t_disable

	initial
	begin
		t_shared_bus();
		t_single_bus();
		t_loopback();
		t_rx_enable();
		t_modes();
		t_five_bit();
		t_repeater();
		t_refused();
		t_disable();
		tally_and_finish();
	end
endmodule : mii_fbi_port_config_tb
